// file: bench/rrmc_rf_source.sv
// Behavioural source of the demodulated bit that the slicer hands the block
`timescale 1ns/1ps
module rrmc_rf_source (
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic        i_level,
  input  wire logic [15:0] i_half,
  output logic             o_bit
);
  int cnt = 0;
  initial o_bit = 1'b0;
  // Changes land 1 ns after the edge, like the bench's own pins
  always @(posedge i_clk) begin
    #1;
    if (!i_run) begin
      cnt = 0;
      o_bit = i_level;
    end else if (cnt >= int'(i_half) - 1) begin
      cnt = 0;
      o_bit = ~o_bit;
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule : rrmc_rf_source

// file: bench/rrmc_top_test.sv
// Self-checking bench for the receiver rate and mode control block
`timescale 1ns/1ps
module rrmc_top_test;
  import rrmc_pkg::*;
  // -------------------------------------------------------------------------
  // Setup
  // -------------------------------------------------------------------------
  localparam int PLL_SIM = 20;
  localparam int HOLD_SIM = 200;
  localparam int LIMIT = 20000;
  logic clk = 0, rst = 1, rx_on = 0, en = 0, rs_lo = 0, rs_hi = 0, dsel = 1;
  logic rssi = 0, sred = 0, run = 0, lvl = 0, bit_w, dout, lat, hto;
  logic [15:0] half = 16'h01f4;
  logic [1:0] rw;
  rrmc_stat_type st;
  int miscompares = 0, checks = 0, cyc = 0;

  always #50 clk = ~clk;

  rrmc_rf_source src (.i_clk(clk), .i_run(run), .i_level(lvl), .i_half(half), .o_bit(bit_w));
  rrmc_top #(.PLL_CYCLES(PLL_SIM), .HOLD_CYCLES(HOLD_SIM)) dut (
    .i_clk(clk), .i_rst(rst), .i_rx_on(rx_on), .i_enable(en),
    .i_rate_select_low(rs_lo), .i_rate_select_high(rs_hi), .i_demod_select(dsel),
    .i_demod_bit(bit_w), .i_rssi_above(rssi), .i_sense_reduce(sred), .o_data(dout),
    .o_rate_window(rw), .o_status(st), .o_sense_latched(lat), .o_hold_timeout(hto));

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Data must stay low until ready; the count bounds the wait
  task automatic wait_ready(output int n);
    n = 0;
    while (st.ready !== 1'b1 && n < 15000) begin
      check(dout, 0, "data not low in start-up");
      tick(1);
      n++;
    end
  endtask : wait_ready

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_startup();
    int n;
    int lo;
    lo = PLL_SIM + SIG3_SCALED * DIV_TICK;
    {rs_hi, rs_lo} = 2'h3;
    half = 16'h01f4;
    run = 1;
    en = 1;
    tick(10);
    check({st.standby, st.active}, 2'h2, "standby not shown");
    rx_on = 1;
    wait_ready(n);
    // First scaled tick lands anywhere within one tick period
    check(n + DIV_TICK >= lo, 1, "start-up too short");
    check(n <= lo + DIV_TICK + 12, 1, "start-up too long");
    check(rw, 2'h3, "range not taken");
    check({st.active, st.ask_mode}, 2'h3, "active ASK not shown");
  endtask : t_startup

  task automatic t_data();
    run = 0;
    lvl = 1;
    tick(8);
    check(dout, 1, "data high not passed");
    lvl = 0;
    tick(8);
    check(dout, 0, "data low not passed");
  endtask : t_data

  task automatic t_hold();
    lvl = 1;
    tick(150);
    check(hto, 0, "gap flagged early");
    tick(80);
    check(hto, 1, "long gap not flagged");
    check(dout, 1, "telegram lost in gap");
  endtask : t_hold

  task automatic t_range_same();
    {rs_hi, rs_lo} = 2'h2;
    tick(10);
    check(rw, 2'h2, "range change not taken");
    check(st.ready, 1, "ready lost on range change");
    tick(RANGE_SW_CYC);
    check(dout, 1, "range change too slow");
  endtask : t_range_same

  // New range is 3, old range 2: the wait must follow range 3
  task automatic t_mode_switch();
    int n;
    int lo;
    lo = SIG3_SCALED * DIV_TICK;
    half = 16'h00fa;
    run = 1;
    dsel = 0;
    {rs_hi, rs_lo} = 2'h3;
    tick(10);
    check(st.ready, 0, "mode change kept ready");
    wait_ready(n);
    check(n + 10 + DIV_TICK >= lo, 1, "mode switch too short");
    check(n + 10 <= lo + DIV_TICK + 12, 1, "mode switch too long");
    check(st.ask_mode, 0, "FSK not shown");
    t_data();
  endtask : t_mode_switch

  task automatic t_sense();
    sred = 1;
    lvl = 1;
    tick(10);
    check({lat, dout}, 2'h0, "data passed below threshold");
    rssi = 1;
    tick(8);
    check({lat, dout}, 2'h3, "latch not set");
    rssi = 0;
    tick(8);
    check(lat, 1, "latch not held");
    dsel = 1;
    tick(6);
    dsel = 0;
    tick(8);
    check(lat, 0, "pulse did not clear latch");
    sred = 0;
  endtask : t_sense

  task automatic t_power();
    rx_on = 0;
    tick(10);
    check({st.standby, st.active, st.ready}, 3'h4, "standby wrong");
    en = 0;
    tick(10);
    check({st.standby, st.active, dout}, 3'h0, "off wrong");
  endtask : t_power

  // -------------------------------------------------------------------------
  // Main sequence and hang guard
  // -------------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    tick(8);
    rst = 0;
    tick(2);
    check({dout, rw, st, lat, hto}, 9'h000, "outputs not clear after reset");
    t_startup();
    t_data();
    t_hold();
    t_range_same();
    t_mode_switch();
    t_sense();
    t_power();
    final_report();
  end
endmodule : rrmc_top_test

// file: hw/rrmc_pkg.sv
// Package of constants and types for the receiver rate and mode control block
package rrmc_pkg;

  // -------------------------------------------------------------------------
  // Timing constants
  // -------------------------------------------------------------------------
  localparam int CLK_MHZ        = 10;
  localparam int DIV_TICK       = 16;
  localparam int RANGE_SW_US    = 100;
  localparam int RANGE_SW_CYC   = RANGE_SW_US * CLK_MHZ;
  localparam int PLL_US         = 261;
  localparam int SIG0_US        = 1096;
  localparam int SIG1_US        = 644;
  localparam int SIG2_US        = 417;
  localparam int SIG3_US        = 304;
  // Signal-processing phase in scaled ticks: us * MHz / (16 * scale)
  localparam int PLL_CYC        = PLL_US * CLK_MHZ;
  localparam int SIG0_SCALED    = (SIG0_US * CLK_MHZ) / (DIV_TICK * 8);
  localparam int SIG1_SCALED    = (SIG1_US * CLK_MHZ) / (DIV_TICK * 4);
  localparam int SIG2_SCALED    = (SIG2_US * CLK_MHZ) / (DIV_TICK * 2);
  localparam int SIG3_SCALED    = (SIG3_US * CLK_MHZ) / (DIV_TICK * 1);
  localparam int HOLD_MS        = 52;
  localparam int HOLD_CYC       = HOLD_MS * 1000 * CLK_MHZ;
  localparam int CNT_W          = 20;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RRMC_OFF     = 2'b00,
    RRMC_STANDBY = 2'b01,
    RRMC_PLL     = 2'b10,
    RRMC_SIG     = 2'b11
  } rrmc_state_type;

  typedef struct packed {
    logic       rx_on;
    logic       enable;
    logic       demod_select;
    logic [1:0] rate_window;
  } rrmc_ctrl_type;

  typedef struct packed {
    logic active;
    logic standby;
    logic ready;
    logic ask_mode;
  } rrmc_stat_type;

endpackage : rrmc_pkg

// file: hw/rrmc_top.sv
// Receiver rate and mode control: power mode, start-up timing and data gating
`timescale 1ns/1ps
module rrmc_top #(
  parameter int PLL_CYCLES  = rrmc_pkg::PLL_CYC,
  parameter int HOLD_CYCLES = rrmc_pkg::HOLD_CYC
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_rx_on,
  input  wire logic                   i_enable,
  input  wire logic                   i_rate_select_low,
  input  wire logic                   i_rate_select_high,
  input  wire logic                   i_demod_select,
  input  wire logic                   i_demod_bit,
  input  wire logic                   i_rssi_above,
  input  wire logic                   i_sense_reduce,
  output logic                        o_data,
  output logic [1:0]                  o_rate_window,
  output rrmc_pkg::rrmc_stat_type     o_status,
  output logic                        o_sense_latched,
  output logic                        o_hold_timeout
);
  import rrmc_pkg::*;

  // -------------------------------------------------------------------------
  // Pin synchronisers: three stages, change accepted when 2nd and 3rd agree
  // -------------------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] clean_r;

  assign raw_w = {i_sense_reduce, i_rssi_above, i_demod_bit, i_demod_select,
                  i_rate_select_high, i_rate_select_low, i_enable, i_rx_on};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      clean_r <= '0;
    end else begin
      s1_r <= raw_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int k = 0; k < NSYNC; k++) begin
        if (s2_r[k] == s3_r[k]) begin
          clean_r[k] <= s3_r[k];
        end
      end
    end
  end

  rrmc_ctrl_type ctrl_w;
  wire           rssi_w  = clean_r[6];
  wire           sense_w = clean_r[7];
  wire           dbit_w  = clean_r[5];
  assign ctrl_w = '{rx_on:        clean_r[0],
                    enable:       clean_r[1],
                    demod_select: clean_r[4],
                    rate_window:  clean_r[3:2]};

  // -------------------------------------------------------------------------
  // Digital tick (clock over 16) and scaled tick per range
  // -------------------------------------------------------------------------
  logic [3:0] div_r;
  logic [2:0] scale_r;
  logic [2:0] scale_max_w;
  wire        tick_w = (div_r == 4'hf);
  wire        stick_w;

  assign scale_max_w = (ctrl_w.rate_window == 2'h0) ? 3'h7 :
                       (ctrl_w.rate_window == 2'h1) ? 3'h3 :
                       (ctrl_w.rate_window == 2'h2) ? 3'h1 : 3'h0;
  assign stick_w = tick_w && (scale_r >= scale_max_w);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_r   <= 4'h0;
      scale_r <= 3'h0;
    end else begin
      div_r <= div_r + 4'h1;
      if (stick_w) begin
        scale_r <= 3'h0;
      end else if (tick_w) begin
        scale_r <= scale_r + 3'h1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Power mode and start-up sequencer
  // -------------------------------------------------------------------------
  rrmc_state_type state_r;
  rrmc_state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] sig_len_w;
  logic [1:0]       rate_r;
  logic             mode_r;
  logic             ready_r;

  wire active_req_w = ctrl_w.rx_on && ctrl_w.enable;
  wire mode_chg_w   = (ctrl_w.demod_select != mode_r);
  wire rate_chg_w   = (ctrl_w.rate_window != rate_r);

  // Length follows the newly selected range, never the old one
  assign sig_len_w = (ctrl_w.rate_window == 2'h0) ? CNT_W'(SIG0_SCALED) :
                     (ctrl_w.rate_window == 2'h1) ? CNT_W'(SIG1_SCALED) :
                     (ctrl_w.rate_window == 2'h2) ? CNT_W'(SIG2_SCALED) :
                                                    CNT_W'(SIG3_SCALED);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!active_req_w) begin
      state_nxt = ctrl_w.enable ? RRMC_STANDBY : RRMC_OFF;
      cnt_nxt   = '0;
    end else begin
      case (state_r)
        RRMC_OFF, RRMC_STANDBY: begin
          state_nxt = RRMC_PLL;
          cnt_nxt   = '0;
        end
        RRMC_PLL: begin
          if (cnt_r >= CNT_W'(PLL_CYCLES - 1)) begin
            state_nxt = RRMC_SIG;
            cnt_nxt   = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        RRMC_SIG: begin
          if (mode_chg_w) begin
            cnt_nxt = '0;
          end else if (rate_chg_w) begin
            // Restart even before ready so the new range's length applies
            cnt_nxt = '0;
          end else if (!ready_r && stick_w) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        default: begin
          state_nxt = RRMC_OFF;
        end
      endcase
    end
  end

  // On-the-fly range switch: short settle in system clocks
  logic [CNT_W-1:0] sw_cnt_r;
  wire  sw_busy_w = (sw_cnt_r != '0);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r  <= RRMC_OFF;
      cnt_r    <= '0;
      rate_r   <= 2'h0;
      mode_r   <= 1'b0;
      ready_r  <= 1'b0;
      sw_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      rate_r  <= ctrl_w.rate_window;
      mode_r  <= ctrl_w.demod_select;
      if (state_nxt != RRMC_SIG || mode_chg_w) begin
        ready_r <= 1'b0;
      end else if (!ready_r && cnt_r >= sig_len_w) begin
        ready_r <= 1'b1;
      end
      if (ready_r && rate_chg_w && !mode_chg_w) begin
        sw_cnt_r <= CNT_W'(RANGE_SW_CYC - 1);
      end else if (sw_busy_w) begin
        sw_cnt_r <= sw_cnt_r - 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Reduced-sensitivity latch, cleared by a rising demod select
  // -------------------------------------------------------------------------
  logic sense_r;
  logic dsel_d_r;
  wire  dsel_rise_w = ctrl_w.demod_select && !dsel_d_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sense_r  <= 1'b0;
      dsel_d_r <= 1'b0;
    end else begin
      dsel_d_r <= ctrl_w.demod_select;
      if (rssi_w && state_r == RRMC_SIG) begin
        sense_r <= 1'b1;                                   // Set wins over clear
      end else if (dsel_rise_w) begin
        sense_r <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Data path and ASK pause supervision
  // -------------------------------------------------------------------------
  logic             data_r;
  logic             dbit_d_r;
  logic [CNT_W+5:0] gap_r;
  logic             hold_to_r;
  wire              pass_w = ready_r && !sw_busy_w && (!sense_w || sense_r);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_r    <= 1'b0;
      dbit_d_r  <= 1'b0;
      gap_r     <= '0;
      hold_to_r <= 1'b0;
    end else begin
      dbit_d_r <= dbit_w;
      // Demodulated bit already high for upper deviation or carrier on
      data_r   <= pass_w ? dbit_w : 1'b0;
      if (!ready_r || dbit_w != dbit_d_r) begin
        gap_r     <= '0;
        hold_to_r <= 1'b0;
      end else if (gap_r < (CNT_W+6)'(HOLD_CYCLES)) begin
        gap_r <= gap_r + 1'b1;
      end else begin
        hold_to_r <= ctrl_w.demod_select;
      end
    end
  end

  assign o_data          = data_r;
  assign o_rate_window   = rate_r;
  assign o_sense_latched = sense_r;
  assign o_hold_timeout  = hold_to_r;
  assign o_status        = '{active:   (state_r == RRMC_PLL) || (state_r == RRMC_SIG),
                             standby:  (state_r == RRMC_STANDBY),
                             ready:    ready_r,
                             ask_mode: mode_r};

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  property p_data_low_startup;
    @(posedge i_clk) disable iff (i_rst)
      !ready_r |=> !o_data;
  endproperty
  a_data_low_startup: assert property (p_data_low_startup)
    else $error("data high during start-up");

  property p_pll_first;
    @(posedge i_clk) disable iff (i_rst)
      $rose(state_r == RRMC_SIG) |-> $past(state_r == RRMC_PLL);
  endproperty
  a_pll_first: assert property (p_pll_first)
    else $error("signal phase not after PLL");

  property p_mode_restart;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == RRMC_SIG && mode_chg_w && active_req_w) |=> !ready_r;
  endproperty
  a_mode_restart: assert property (p_mode_restart)
    else $error("mode change kept ready");

  property p_off_mode;
    @(posedge i_clk) disable iff (i_rst)
      (!ctrl_w.enable && !ctrl_w.rx_on) |=> state_r == RRMC_OFF;
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("not off with both pins low");

  property p_range_switch;
    @(posedge i_clk) disable iff (i_rst)
      $rose(sw_busy_w) |-> ##[1:1000] !sw_busy_w;
  endproperty
  a_range_switch: assert property (p_range_switch)
    else $error("range switch too slow");

  property p_sense_clear;
    @(posedge i_clk) disable iff (i_rst)
      (dsel_rise_w && !(rssi_w && state_r == RRMC_SIG)) |=> !sense_r;
  endproperty
  a_sense_clear: assert property (p_sense_clear)
    else $error("latch not cleared");

  property p_data_follows;
    @(posedge i_clk) disable iff (i_rst)
      pass_w |=> o_data == $past(dbit_w);
  endproperty
  a_data_follows: assert property (p_data_follows)
    else $error("data does not follow demod bit");

  property p_scaled_tick;
    @(posedge i_clk) disable iff (i_rst)
      (stick_w && ctrl_w.rate_window == 2'h3)
        |-> ##16 (tick_w && (stick_w || ctrl_w.rate_window != 2'h3));
  endproperty
  a_scaled_tick: assert property (p_scaled_tick)
    else $error("scaled tick period wrong");

endmodule : rrmc_top
